/* File: design/sfe_pkg.sv */
package sfe_pkg;

  // Command opcodes
  localparam logic [7:0] OP_LATCH_SET      = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR    = 8'h04;
  localparam logic [7:0] OP_STATUS_READ    = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
  localparam logic [7:0] OP_READ           = 8'h03;
  localparam logic [7:0] OP_FAST_READ      = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT_READ  = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT_READ  = 8'h6b;
  localparam logic [7:0] OP_DUAL_ADDR_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_ADDR_READ = 8'heb;
  localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20;
  localparam logic [7:0] OP_LARGE_ERASE    = 8'hd8;
  localparam logic [7:0] OP_HALF_ERASE     = 8'h52;
  localparam logic [7:0] OP_CHIP_ERASE_A   = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B   = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROG      = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h38;
  localparam logic [7:0] OP_PD_ENTER       = 8'hb9;
  localparam logic [7:0] OP_PD_RELEASE     = 8'hab;

  // Lane codes: clocks per byte is 8 shifted right by the code
  localparam logic [1:0] LANE_ONE  = 2'h0;
  localparam logic [1:0] LANE_TWO  = 2'h1;
  localparam logic [1:0] LANE_FOUR = 2'h2;

  // Phase lengths in serial clocks on one lane
  localparam logic [4:0] CMD_CLKS  = 5'h08;
  localparam logic [4:0] ADDR_CLKS = 5'h18;
  localparam logic [4:0] BYTE_CLKS = 5'h08;
  localparam logic [4:0] RES_DUMMY = 5'h18;

  // Dummy clocks per read variant and frequency class
  localparam logic [4:0] DUMMY_FAST     = 5'h08;
  localparam logic [4:0] DUMMY_DUAL_LO  = 5'h04;
  localparam logic [4:0] DUMMY_DUAL_HI  = 5'h08;
  localparam logic [4:0] DUMMY_QUAD_LO  = 5'h06;
  localparam logic [4:0] DUMMY_QUAD_HI  = 5'h0a;

  // Array geometry
  localparam int         ADDR_W         = 24;
  localparam int         PAGE_BYTES     = 256;
  localparam int         SECTOR_COUNT   = 2048;
  localparam int         HALF_COUNT     = 256;
  localparam int         LARGE_COUNT    = 128;
  localparam int         SECTOR_SHIFT   = 12;
  localparam int         HALF_SHIFT     = 15;
  localparam int         LARGE_SHIFT    = 16;

  // Status byte layout and reset values
  localparam int         SR_BUSY_BIT    = 0;
  localparam int         SR_LATCH_BIT   = 1;
  localparam int         SR_PROT_LSB    = 2;
  localparam int         SR_UPPER_LSB   = 2;
  localparam logic [5:0] SR_UPPER_RESET = 6'h00;

  // Erase granularity reported to the array engine
  localparam logic [1:0] ERASE_SECTOR = 2'h0;
  localparam logic [1:0] ERASE_HALF   = 2'h1;
  localparam logic [1:0] ERASE_LARGE  = 2'h2;
  localparam logic [1:0] ERASE_CHIP   = 2'h3;

  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_DOUT, ST_DIN, ST_DONE, ST_IGNORE
  } sfe_state_t;

endpackage

/* File: design/sfe_front_end.sv */
// Operation
// - Serial modes 0 and 3 both supported.
// - Single lane: in on 0, out on 1.
// - Deselected and idle means standby.
// - Quad mode uses all four data lines.
// - Dual mode uses lines 0 and 1.
// - Hold low pauses transfer, stays selected.
// - 06 sets write latch, 04 clears it.
// - 05 reads status, 01 writes status.
// - 03 plain read, 0B fast read.
// - 3B dual output, 6B quad output read.
// - BB dual address, EB quad address read.
// - Fast, dual and quad output: 8 dummies.
// - Dual address read: 4 or 8 dummies.
// - Quad address read: 6 or 10 dummies.
// - Burst wrap within 8/16/32/64 byte windows.
// - 20, D8, 52 erase 4K, 64K, 32K.
// - 60 or C7 erases whole array.
// - 02 page program, 38 quad program.
// - Program bytes or pages up to 256.
// - 2048 sectors, 256 and 128 blocks.
// - Busy flag set while program/erase runs.
// - B9 powers down, AB releases, returns id.
// - Alterations need the write latch set.
// - Chip erase only with protect bits zero.
`timescale 1ns/1ps
module sfe_front_end #(
  parameter logic [7:0] DEVICE_ID = 8'h5a  // Arbitrary identifier value
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Serial link pins
  input  wire logic       sclkIn,
  input  wire logic       csN,
  input  wire logic [3:0] dataLineIn,
  output wire logic [3:0] dataLineOut,
  output wire logic [3:0] dataLineOe,
  // Configuration
  input  wire logic       cfgHighFreqDummy,
  input  wire logic       wrapEnable,
  input  wire logic [1:0] wrapSize,
  // Array engine
  output wire logic [23:0] memAddr,
  input  wire logic [7:0]  memRdData,
  output wire logic [7:0]  progData,
  output wire logic        progByteValid,
  output wire logic        progStart,
  output wire logic        eraseStart,
  output wire logic [1:0]  eraseKind,
  input  wire logic        opDone,
  // Status
  output wire logic       opInProgressFlag,
  output wire logic       writeLatchFlag,
  output wire logic [3:0] protectLevelBits,
  output wire logic       powerDown,
  output wire logic       standby
);

  // Decode helpers used at several places
  function automatic logic isRead(input logic [7:0] op);
    isRead = (op == sfe_pkg::OP_READ) || (op == sfe_pkg::OP_FAST_READ) ||
             (op == sfe_pkg::OP_DUAL_OUT_READ) || (op == sfe_pkg::OP_QUAD_OUT_READ) ||
             (op == sfe_pkg::OP_DUAL_ADDR_READ) || (op == sfe_pkg::OP_QUAD_ADDR_READ);
  endfunction

  function automatic logic isErase(input logic [7:0] op);
    isErase = (op == sfe_pkg::OP_SECTOR_ERASE) || (op == sfe_pkg::OP_LARGE_ERASE) ||
              (op == sfe_pkg::OP_HALF_ERASE);
  endfunction

  function automatic logic isProg(input logic [7:0] op);
    isProg = (op == sfe_pkg::OP_PAGE_PROG) || (op == sfe_pkg::OP_QUAD_PAGE_PROG);
  endfunction

  function automatic logic [1:0] addrLane(input logic [7:0] op);
    case (op)
      sfe_pkg::OP_DUAL_ADDR_READ: addrLane = sfe_pkg::LANE_TWO;
      sfe_pkg::OP_QUAD_ADDR_READ,
      sfe_pkg::OP_QUAD_PAGE_PROG: addrLane = sfe_pkg::LANE_FOUR;
      default:                    addrLane = sfe_pkg::LANE_ONE;
    endcase
  endfunction

  function automatic logic [1:0] dataLane(input logic [7:0] op);
    case (op)
      sfe_pkg::OP_DUAL_OUT_READ,
      sfe_pkg::OP_DUAL_ADDR_READ: dataLane = sfe_pkg::LANE_TWO;
      sfe_pkg::OP_QUAD_OUT_READ,
      sfe_pkg::OP_QUAD_ADDR_READ,
      sfe_pkg::OP_QUAD_PAGE_PROG: dataLane = sfe_pkg::LANE_FOUR;
      default:                    dataLane = sfe_pkg::LANE_ONE;
    endcase
  endfunction

  function automatic logic [4:0] dummyClks(input logic [7:0] op, input logic hi);
    case (op)
      sfe_pkg::OP_FAST_READ,
      sfe_pkg::OP_DUAL_OUT_READ,
      sfe_pkg::OP_QUAD_OUT_READ:  dummyClks = sfe_pkg::DUMMY_FAST;
      sfe_pkg::OP_DUAL_ADDR_READ: dummyClks = hi ? sfe_pkg::DUMMY_DUAL_HI : sfe_pkg::DUMMY_DUAL_LO;
      sfe_pkg::OP_QUAD_ADDR_READ: dummyClks = hi ? sfe_pkg::DUMMY_QUAD_HI : sfe_pkg::DUMMY_QUAD_LO;
      default:                    dummyClks = 5'h00;
    endcase
  endfunction

  // Link inputs pass two flip-flops before any logic reads them
  logic [5:0] syncA_ff;
  logic [5:0] syncB_ff;
  logic       sclkPrev_ff;
  logic       csPrev_ff;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      syncA_ff    <= 6'h10;
      syncB_ff    <= 6'h10;
      sclkPrev_ff <= 1'b0;
      csPrev_ff   <= 1'b1;
    end else begin
      syncA_ff    <= {sclkIn, csN, dataLineIn};
      syncB_ff    <= syncA_ff;
      sclkPrev_ff <= syncB_ff[5];
      csPrev_ff   <= syncB_ff[4];
    end
  end

  // State registers
  sfe_pkg::sfe_state_t state_ff;
  logic [7:0]  opcode_ff;
  logic [4:0]  cnt_ff;
  logic [1:0]  lane_ff;
  logic        quadCmd_ff;
  logic [7:0]  inSh_ff;
  logic [23:0] addr_ff;
  logic [23:0] memAddr_ff;
  logic [7:0]  outSh_ff;
  logic [3:0]  bitsLeft_ff;
  logic        first_ff;
  logic [8:0]  progCount_ff;
  logic [7:0]  srPend_ff;
  logic        srGot_ff;
  logic [5:0]  srUpper_ff;
  logic        wel_ff;
  logic        wip_ff;
  logic        pd_ff;
  logic [7:0]  progData_ff;
  logic        progByte_ff;
  logic        progStart_ff;
  logic        eraseStart_ff;
  logic [1:0]  eraseKind_ff;

  // Edge detection on the synchronised link clock and select
  wire logic       csLow    = ~syncB_ff[4];
  wire logic [3:0] din      = syncB_ff[3:0];
  wire logic       holdAct  = csLow & ~din[3] & ~quadCmd_ff;
  wire logic       riseEv   = syncB_ff[5] & ~sclkPrev_ff & csLow & ~holdAct;
  wire logic       fallEv   = ~syncB_ff[5] & sclkPrev_ff & csLow & ~holdAct;
  wire logic       csRise   = syncB_ff[4] & ~csPrev_ff;

  // Lane gathering: new bits enter at the bottom, MSB first
  wire logic [4:0] byteClks = sfe_pkg::BYTE_CLKS >> lane_ff;
  wire logic [7:0] nxt_inSh = (lane_ff == sfe_pkg::LANE_FOUR) ? {inSh_ff[3:0], din} :
                              (lane_ff == sfe_pkg::LANE_TWO)  ? {inSh_ff[5:0], din[1:0]} :
                                                                {inSh_ff[6:0], din[0]};
  wire logic [23:0] nxt_addr = (lane_ff == sfe_pkg::LANE_FOUR) ? {addr_ff[19:0], din} :
                               (lane_ff == sfe_pkg::LANE_TWO)  ? {addr_ff[21:0], din[1:0]} :
                                                                 {addr_ff[22:0], din[0]};
  wire logic [7:0] cmdByte  = {inSh_ff[6:0], din[0]};
  wire logic       lastClk  = (cnt_ff == 5'h01);

  // Status byte as read by the host
  wire logic [7:0] statusByte = {srUpper_ff, wel_ff, wip_ff};

  // Burst wrap keeps the upper address bits and wraps inside the window
  wire logic [5:0]  wrapMask = {wrapSize == 2'h3, wrapSize[1], wrapSize != 2'h0, 3'h7};
  wire logic [23:0] incAddr  = memAddr_ff + 24'h000001;
  wire logic [23:0] winMask  = {18'h0, wrapMask};
  wire logic [23:0] nxt_rdAddr = wrapEnable ? ((memAddr_ff & ~winMask) | (incAddr & winMask)) :
                                              incAddr;

  // Data source for the next outgoing byte
  wire logic [7:0] outSrc   = (opcode_ff == sfe_pkg::OP_STATUS_READ) ? statusByte :
                              (opcode_ff == sfe_pkg::OP_PD_RELEASE)  ? DEVICE_ID :
                                                                       memRdData;
  // Bits per link clock on the active lanes; reload once the last group has gone out
  wire logic [3:0] laneBits = 4'h1 << lane_ff;
  wire logic       loadNow  = first_ff || (bitsLeft_ff == laneBits);

  // Decisions taken when select rises
  wire logic       aligned    = (cnt_ff == byteClks);
  wire logic       protClear  = (srUpper_ff[3:0] == 4'h0);
  wire logic       eraseOk    = (state_ff == sfe_pkg::ST_DONE) && wel_ff && !wip_ff &&
                                (isErase(opcode_ff) ||
                                 (((opcode_ff == sfe_pkg::OP_CHIP_ERASE_A) ||
                                   (opcode_ff == sfe_pkg::OP_CHIP_ERASE_B)) && protClear));
  wire logic       progOk     = (state_ff == sfe_pkg::ST_DIN) && isProg(opcode_ff) && aligned &&
                                wel_ff && (progCount_ff != 9'h000);
  wire logic       srWriteOk  = (state_ff == sfe_pkg::ST_DIN) && aligned && srGot_ff && wel_ff &&
                                (opcode_ff == sfe_pkg::OP_STATUS_WRITE);
  wire logic [1:0] kindSel    = (opcode_ff == sfe_pkg::OP_SECTOR_ERASE) ? sfe_pkg::ERASE_SECTOR :
                                (opcode_ff == sfe_pkg::OP_HALF_ERASE)   ? sfe_pkg::ERASE_HALF :
                                (opcode_ff == sfe_pkg::OP_LARGE_ERASE)  ? sfe_pkg::ERASE_LARGE :
                                                                          sfe_pkg::ERASE_CHIP;
  // Erase start address aligned to the unit: 2048, 256 or 128 units in the array
  wire logic [23:0] eraseAddr = (kindSel == sfe_pkg::ERASE_SECTOR) ? {addr_ff[23:sfe_pkg::SECTOR_SHIFT], 12'h000} :
                                (kindSel == sfe_pkg::ERASE_HALF)   ? {addr_ff[23:sfe_pkg::HALF_SHIFT], 15'h0} :
                                (kindSel == sfe_pkg::ERASE_LARGE)  ? {addr_ff[23:sfe_pkg::LARGE_SHIFT], 16'h0000} :
                                                                     24'h000000;

  // Command byte decode into the next phase
  sfe_pkg::sfe_state_t cmdNext;
  always_comb begin
    if (pd_ff && cmdByte != sfe_pkg::OP_PD_RELEASE) begin
      cmdNext = sfe_pkg::ST_IGNORE;
    end else if (wip_ff && cmdByte != sfe_pkg::OP_STATUS_READ) begin
      cmdNext = sfe_pkg::ST_IGNORE;
    end else if (isRead(cmdByte) || isErase(cmdByte) || isProg(cmdByte)) begin
      cmdNext = sfe_pkg::ST_ADDR;
    end else if (cmdByte == sfe_pkg::OP_PD_RELEASE) begin
      cmdNext = sfe_pkg::ST_DUMMY;
    end else if (cmdByte == sfe_pkg::OP_STATUS_READ) begin
      cmdNext = sfe_pkg::ST_DOUT;
    end else if (cmdByte == sfe_pkg::OP_STATUS_WRITE) begin
      cmdNext = sfe_pkg::ST_DIN;
    end else if (cmdByte == sfe_pkg::OP_LATCH_SET || cmdByte == sfe_pkg::OP_LATCH_CLEAR ||
                 cmdByte == sfe_pkg::OP_PD_ENTER || cmdByte == sfe_pkg::OP_CHIP_ERASE_A ||
                 cmdByte == sfe_pkg::OP_CHIP_ERASE_B) begin
      cmdNext = sfe_pkg::ST_DONE;
    end else begin
      cmdNext = sfe_pkg::ST_IGNORE;
    end
  end

  // Phase sequencer driven by rising link clock edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff   <= sfe_pkg::ST_CMD;
      opcode_ff  <= 8'h00;
      cnt_ff     <= sfe_pkg::CMD_CLKS;
      lane_ff    <= sfe_pkg::LANE_ONE;
      quadCmd_ff <= 1'b0;
      inSh_ff    <= 8'h00;
      addr_ff    <= 24'h000000;
    end else if (!csLow) begin
      state_ff   <= sfe_pkg::ST_CMD;  // Frame ends on select high
      cnt_ff     <= sfe_pkg::CMD_CLKS;
      lane_ff    <= sfe_pkg::LANE_ONE;
      quadCmd_ff <= 1'b0;
    end else if (riseEv) begin
      case (state_ff)
        sfe_pkg::ST_CMD: begin
          inSh_ff <= nxt_inSh;
          cnt_ff  <= cnt_ff - 5'h01;
          if (lastClk) begin
            opcode_ff  <= cmdByte;
            state_ff   <= cmdNext;
            quadCmd_ff <= (dataLane(cmdByte) == sfe_pkg::LANE_FOUR);  // Hold pin becomes data
            lane_ff    <= addrLane(cmdByte);
            cnt_ff     <= (cmdNext == sfe_pkg::ST_ADDR)  ? (sfe_pkg::ADDR_CLKS >> addrLane(cmdByte)) :
                          (cmdNext == sfe_pkg::ST_DUMMY) ? sfe_pkg::RES_DUMMY : sfe_pkg::BYTE_CLKS;
          end
        end
        sfe_pkg::ST_ADDR: begin
          addr_ff <= nxt_addr;
          cnt_ff  <= cnt_ff - 5'h01;
          if (lastClk) begin
            lane_ff <= dataLane(opcode_ff);
            if (dummyClks(opcode_ff, cfgHighFreqDummy) != 5'h00) begin
              state_ff <= sfe_pkg::ST_DUMMY;
              cnt_ff   <= dummyClks(opcode_ff, cfgHighFreqDummy);
            end else if (isRead(opcode_ff)) begin
              state_ff <= sfe_pkg::ST_DOUT;
            end else if (isProg(opcode_ff)) begin
              state_ff <= sfe_pkg::ST_DIN;
              cnt_ff   <= sfe_pkg::BYTE_CLKS >> dataLane(opcode_ff);
            end else begin
              state_ff <= sfe_pkg::ST_DONE;
            end
          end
        end
        sfe_pkg::ST_DUMMY: begin
          cnt_ff <= cnt_ff - 5'h01;
          if (lastClk) begin
            state_ff <= sfe_pkg::ST_DOUT;
          end
        end
        sfe_pkg::ST_DIN: begin
          inSh_ff <= nxt_inSh;
          cnt_ff  <= lastClk ? byteClks : cnt_ff - 5'h01;
        end
        sfe_pkg::ST_DONE: begin
          state_ff <= sfe_pkg::ST_IGNORE;  // Extra clocks break the byte boundary
        end
        default: begin
          state_ff <= state_ff;
        end
      endcase
    end
  end

  // Outgoing data shifts on falling edges so it is stable at the next rise
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      outSh_ff    <= 8'h00;
      bitsLeft_ff <= 4'h0;
      first_ff    <= 1'b1;
    end else if (!csLow || state_ff != sfe_pkg::ST_DOUT) begin
      first_ff <= 1'b1;
    end else if (fallEv) begin
      first_ff    <= 1'b0;
      outSh_ff    <= loadNow ? outSrc : (outSh_ff << laneBits);
      bitsLeft_ff <= loadNow ? 4'h8 : bitsLeft_ff - laneBits;
    end
  end

  // Array address pointer and program byte stream
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      memAddr_ff   <= 24'h000000;
      progData_ff  <= 8'h00;
      progByte_ff  <= 1'b0;
      progCount_ff <= 9'h000;
      srPend_ff    <= 8'h00;
      srGot_ff     <= 1'b0;
    end else begin
      progByte_ff <= 1'b0;
      if (!csLow) begin
        srGot_ff <= csRise ? 1'b0 : srGot_ff;
        if (csRise && eraseOk) begin
          memAddr_ff <= eraseAddr;
        end
        if (csRise) begin
          progCount_ff <= 9'h000;
        end
      end else if (state_ff == sfe_pkg::ST_ADDR && riseEv && lastClk) begin
        memAddr_ff <= nxt_addr;  // Read pointer starts at the collected address
      end else if (state_ff == sfe_pkg::ST_DOUT && fallEv && loadNow && isRead(opcode_ff)) begin
        memAddr_ff <= nxt_rdAddr;
      end else if (state_ff == sfe_pkg::ST_DIN && riseEv && lastClk) begin
        if (isProg(opcode_ff)) begin
          memAddr_ff   <= addr_ff;
          progData_ff  <= nxt_inSh;
          progByte_ff  <= wel_ff;
          // Page offset wraps; count saturates at one page
          addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
          progCount_ff <= (progCount_ff == 9'(sfe_pkg::PAGE_BYTES)) ? progCount_ff
                                                                     : progCount_ff + 9'h001;
        end else if (!srGot_ff) begin
          srPend_ff <= nxt_inSh;
          srGot_ff  <= 1'b1;
        end
      end
    end
  end

  // Latch, busy, protection and power state, updated as the frame closes; busy clears on opDone
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      srUpper_ff    <= sfe_pkg::SR_UPPER_RESET;
      wel_ff        <= 1'b0;
      wip_ff        <= 1'b0;
      pd_ff         <= 1'b0;
      progStart_ff  <= 1'b0;
      eraseStart_ff <= 1'b0;
      eraseKind_ff  <= sfe_pkg::ERASE_SECTOR;
    end else begin
      progStart_ff  <= csRise && progOk;
      eraseStart_ff <= csRise && eraseOk;
      if (csRise && eraseOk) begin
        eraseKind_ff <= kindSel;
      end
      // Start wins over a completion arriving in the same cycle
      wip_ff <= (csRise && (progOk || eraseOk)) ? 1'b1 : (opDone ? 1'b0 : wip_ff);
      if (csRise && (progOk || eraseOk || srWriteOk)) begin
        wel_ff <= 1'b0;
      end else if (csRise && state_ff == sfe_pkg::ST_DONE && opcode_ff == sfe_pkg::OP_LATCH_SET) begin
        wel_ff <= 1'b1;
      end else if (csRise && state_ff == sfe_pkg::ST_DONE && opcode_ff == sfe_pkg::OP_LATCH_CLEAR) begin
        wel_ff <= 1'b0;
      end
      if (csRise && srWriteOk) begin
        srUpper_ff <= srPend_ff[7:sfe_pkg::SR_UPPER_LSB];
      end
      if (csRise && state_ff == sfe_pkg::ST_DONE && opcode_ff == sfe_pkg::OP_PD_ENTER) begin
        pd_ff <= 1'b1;
      end else if (csRise && opcode_ff == sfe_pkg::OP_PD_RELEASE &&
                   (state_ff == sfe_pkg::ST_DUMMY || state_ff == sfe_pkg::ST_DOUT)) begin
        pd_ff <= 1'b0;
      end
    end
  end

  // Lane drive: single uses line 1, dual lines 1..0, quad lines 3..0
  wire logic       driving  = csLow && !holdAct && !first_ff && (state_ff == sfe_pkg::ST_DOUT);
  wire logic [3:0] laneMask = (lane_ff == sfe_pkg::LANE_FOUR) ? 4'hf :
                              (lane_ff == sfe_pkg::LANE_TWO)  ? 4'h3 : 4'h2;
  assign dataLineOut = (lane_ff == sfe_pkg::LANE_FOUR) ? outSh_ff[7:4] :
                       (lane_ff == sfe_pkg::LANE_TWO)  ? {2'b00, outSh_ff[7:6]} :
                                                         {2'b00, outSh_ff[7], 1'b0};
  assign dataLineOe  = driving ? laneMask : 4'h0;

  // Outputs to the array engine and status pins
  assign memAddr          = memAddr_ff;
  assign progData         = progData_ff;
  assign progByteValid    = progByte_ff;
  assign progStart        = progStart_ff;
  assign eraseStart       = eraseStart_ff;
  assign eraseKind        = eraseKind_ff;
  assign opInProgressFlag = wip_ff;
  assign writeLatchFlag   = wel_ff;
  assign protectLevelBits = srUpper_ff[3:0];
  assign powerDown        = pd_ff;
  assign standby          = !csLow && !wip_ff;

endmodule

/* File: sim/sfe_chk.sv */
`timescale 1ns/1ps
module sfe_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Watched pins
  input wire logic        csN,
  input wire logic [3:0]  dataLineOe,
  input wire logic [23:0] memAddr,
  input wire logic        progByteValid,
  input wire logic        progStart,
  input wire logic        eraseStart,
  input wire logic [1:0]  eraseKind,
  input wire logic        opDone,
  input wire logic        opInProgressFlag,
  input wire logic        writeLatchFlag,
  input wire logic [3:0]  protectLevelBits,
  input wire logic        standby
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_busy_no_standby: assert property (opInProgressFlag |-> !standby) else $error("standby while busy");
  chk_select_wakes: assert property (!csN [*3] |-> !standby) else $error("standby while selected");
  chk_lines_released: assert property (csN [*5] |-> dataLineOe == 4'h0) else $error("driving while idle");
  chk_prog_latch: assert property (progByteValid |-> writeLatchFlag) else $error("program without latch");
  chk_prog_busy: assert property (progStart |-> ##2 (opInProgressFlag && !writeLatchFlag))
    else $error("program start without busy");
  chk_erase_busy: assert property (eraseStart |-> ##2 (opInProgressFlag && !writeLatchFlag))
    else $error("erase start without busy");
  chk_chip_protect: assert property (eraseStart |-> ##1 (eraseKind != 2'h3 || protectLevelBits == 4'h0))
    else $error("chip erase while protected");
  chk_erase_align: assert property (eraseStart |-> ##1 (eraseKind == 2'h3 || memAddr[11:0] == 12'h000))
    else $error("erase address not aligned");
  chk_start_pulse: assert property ((progStart || eraseStart) |=> !(progStart || eraseStart))
    else $error("start longer than one cycle");
  chk_done_clears: assert property ($rose(opDone) && opInProgressFlag |=> !opInProgressFlag)
    else $error("busy stuck after done");
  chk_latch_deselect: assert property ($rose(writeLatchFlag) |-> csN) else $error("latch set mid frame");
  // Main scenarios
  cov_prog: cover property (progStart);
  cov_chip: cover property (eraseStart ##1 eraseKind == 2'h3);
  cov_latch_drop: cover property ($fell(writeLatchFlag));
endmodule

/* File: sim/sfe_host.sv */
`timescale 1ns/1ps
module sfe_host (
  // Serial pins toward the flash
  output logic      sclk,
  output logic      csN,
  output logic      txBit,
  input  wire logic rxBit
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    txBit = 1'b1;
  end
  // Mode 0 byte: MSB first, launched on the fall, taken on the rise
  task automatic xb(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      txBit = b[i];
      #62.5 sclk = 1'b1;
      r[i] = rxBit;
      #62.5 sclk = 1'b0;
    end
  endtask
  // Released line flips so a stale bit cannot pass for data
  task automatic sel(input logic on);
    #200 csN = ~on;
    txBit = ~txBit;
    #200;
  endtask
endmodule

/* File: sim/serial_nor_flash_command_front_end_tb.sv */
`timescale 1ns/1ps
module serial_nor_flash_command_front_end_tb;
  // Clock, reset and configuration, tied except wrapEnable
  logic        core_clk = 1'b0, reset = 1'b1, opDone = 1'b0;
  logic        cfgHighFreqDummy = 1'b0, wrapEnable = 1'b0;
  logic [1:0]  wrapSize = 2'h0;
  // Pins and array engine
  logic        sclk, csN, txBit;
  wire  [3:0]  dataLineOut, dataLineOe, protectLevelBits;
  wire  [23:0] memAddr;
  wire  [7:0]  progData;
  wire  [1:0]  eraseKind;
  wire         progByteValid, progStart, eraseStart, opInProgressFlag, writeLatchFlag, powerDown, standby;
  // Hold and protect pulled up; released line 1 shows the inverse
  wire  [3:0]  dataLineIn = {2'h3, dataLineOe[1] ? dataLineOut[1] : ~dataLineOut[1], txBit};
  wire  [7:0]  memRdData = memAddr[7:0] ^ memAddr[15:8];
  int          fails = 0, compares = 0, pCnt = 0;
  logic [31:0] seed = 32'h9bb6;
  logic [23:0] lastPa;
  localparam logic [7:0] ID = 8'h5a;  // Arbitrary identifier value
  logic [7:0]  lastPd, wbuf [4], rbuf [4];
  logic [7:0]  eCmd [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
  sfe_front_end #(.DEVICE_ID(ID)) u_dut (
    .core_clk(core_clk), .reset(reset), .sclkIn(sclk), .csN(csN), .dataLineIn(dataLineIn),
    .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .cfgHighFreqDummy(cfgHighFreqDummy),
    .wrapEnable(wrapEnable), .wrapSize(wrapSize), .memAddr(memAddr), .memRdData(memRdData),
    .progData(progData), .progByteValid(progByteValid), .progStart(progStart), .eraseStart(eraseStart),
    .eraseKind(eraseKind), .opDone(opDone), .opInProgressFlag(opInProgressFlag),
    .writeLatchFlag(writeLatchFlag), .protectLevelBits(protectLevelBits), .powerDown(powerDown),
    .standby(standby));
  sfe_host u_host (.sclk(sclk), .csN(csN), .txBit(txBit), .rxBit(dataLineIn[1]));
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (progByteValid) begin
    pCnt <= pCnt + 1;
    lastPd <= progData;
    lastPa <= memAddr;
  end
  function logic [23:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[23:0];
  endfunction
  // Array content model: what a read of address x must return
  function logic [7:0] rdv(input logic [23:0] x);
    return x[7:0] ^ x[15:8];
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Command, optional address, then nD bytes from wbuf answered into rbuf
  task automatic frame(input logic [7:0] cmd, input bit ad, input logic [23:0] a, input int nD);
    logic [7:0] r;
    u_host.sel(1'b1);
    u_host.xb(cmd, r);
    if (ad) for (int k = 2; k >= 0; k--) u_host.xb(a[8*k +: 8], r);
    for (int k = 0; k < nD; k++) u_host.xb(wbuf[k], rbuf[k]);
    u_host.sel(1'b0);
  endtask
  task automatic done_op;
    @(negedge core_clk) opDone = 1'b1;
    @(negedge core_clk) opDone = 1'b0;
    @(negedge core_clk) check(opInProgressFlag, 1'b0);
  endtask
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400us fails++;
    print_verdict();
  end
  initial begin
    logic [23:0] a;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    frame(8'h05, 0, 0, 1);
    check(rbuf[0], 8'h00);
    check(standby, 1'b1);
    frame(8'h06, 0, 0, 0);
    check(writeLatchFlag, 1'b1);
    frame(8'h04, 0, 0, 0);
    check(writeLatchFlag, 1'b0);
    $display("latch test done");
    // Erase before programming, every erase opcode once
    for (int k = 0; k < 5; k++) begin
      a = rnd();
      frame(8'h06, 0, 0, 0);
      frame(eCmd[k], k < 3, a, 0);
      check(opInProgressFlag, 1'b1);
      check(eraseKind, k < 3 ? k : 3);
      if (k < 3) check(memAddr, a & (k == 0 ? 24'hfff000 : k == 1 ? 24'hff8000 : 24'hff0000));
      done_op();
    end
    $display("erase test done");
    wbuf[0] = 8'(rnd());
    wbuf[1] = 8'(rnd());
    frame(8'h02, 1, a, 2);
    check(pCnt, 0);
    check(opInProgressFlag, 1'b0);
    frame(8'h06, 0, 0, 0);
    frame(8'h02, 1, a, 2);
    check({pCnt[7:0], lastPd}, {8'h02, wbuf[1]});
    check(lastPa, {a[23:8], a[7:0] + 8'h01});
    frame(8'h05, 0, 0, 1);
    check(rbuf[0][1:0], 2'h1);
    done_op();
    $display("program test done");
    a = rnd();
    frame(8'h03, 1, a, 2);
    check({rbuf[0], rbuf[1]}, {rdv(a), rdv(a + 24'h000001)});
    frame(8'h0b, 1, a, 3);
    check({rbuf[1], rbuf[2]}, {rdv(a), rdv(a + 24'h000001)});
    // Corner case: last byte of an 8-byte window wraps back to its start
    @(negedge core_clk) wrapEnable = 1'b1;
    a = rnd() | 24'h000007;
    frame(8'h03, 1, a, 2);
    check({rbuf[0], rbuf[1]}, {rdv(a), rdv(a & 24'hfffff8)});
    $display("read test done");
    frame(8'hb9, 0, 0, 0);
    check(powerDown, 1'b1);
    frame(8'h06, 0, 0, 0);
    check(writeLatchFlag, 1'b0);
    frame(8'hab, 0, 0, 4);
    check({rbuf[3], 7'h00, powerDown}, {ID, 8'h00});
    $display("power test done");
    print_verdict();
  end
endmodule
bind sfe_front_end sfe_chk u_chk (.*);
